// ===== design/fqs_pkg.sv
// fqs_pkg: opcodes, register fields, address masks and timing counts
// assumes a 10 MHz core clock; every cycle count derives from CLK_NS
package fqs_pkg;
    // core clock and typical suspend timings
    localparam int unsigned CLK_NS   = 100;
    localparam int unsigned T_SUS_US = 100;
    localparam int unsigned T_SS_US  = 80;
    localparam int unsigned SUS_CYC  = (T_SUS_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SS_CYC   = (T_SS_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam logic [9:0]  SUS_LD   = 10'(SUS_CYC);
    localparam logic [9:0]  SS_LD    = 10'(SS_CYC);
    // opcodes handled here
    localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
    localparam logic [7:0] OP_STATUS_READ_CMD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE_CMD   = 8'h01;
    localparam logic [7:0] OP_FUNCTION_REG_READ_CMD   = 8'h48;
    localparam logic [7:0] OP_FUNCTION_REG_WRITE_CMD   = 8'h42;
    localparam logic [7:0] OP_QEN    = 8'h35;
    localparam logic [7:0] OP_QEX    = 8'hf5;
    localparam logic [7:0] OP_SUS_A  = 8'h75;
    localparam logic [7:0] OP_SUS_B  = 8'hb0;
    localparam logic [7:0] OP_RSM_A  = 8'h7a;
    localparam logic [7:0] OP_RSM_B  = 8'h30;
    localparam logic [7:0] OP_PP     = 8'h02;
    localparam logic [7:0] OP_PPQ    = 8'h32;
    localparam logic [7:0] OP_SE_A   = 8'h20;
    localparam logic [7:0] OP_SE_B   = 8'hd7;
    localparam logic [7:0] OP_BE32   = 8'h52;
    localparam logic [7:0] OP_BE64   = 8'hd8;
    localparam logic [7:0] OP_CE_A   = 8'hc7;
    localparam logic [7:0] OP_CE_B   = 8'h60;
    localparam logic [7:0] OP_RD     = 8'h03;
    localparam logic [7:0] OP_FRD    = 8'h0b;
    localparam logic [7:0] OP_RD_DO  = 8'h3b;
    localparam logic [7:0] OP_RD_QO  = 8'h6b;
    localparam logic [7:0] OP_RD_DIO = 8'hbb;
    localparam logic [7:0] OP_RD_QIO = 8'heb;
    // opcodes still taken while an operation is suspended
    localparam logic [7:0] SUSP_OK [33] = '{OP_RD, 8'h13, OP_FRD, 8'h0c, OP_RD_DIO,
        8'hbc, OP_RD_DO, 8'h3c, OP_RD_QIO, 8'hec, OP_RD_QO, 8'h6c, 8'h0d, 8'h0e,
        8'hbd, 8'hbe, 8'hed, 8'hee, OP_WRITE_ENABLE_CMD, OP_WRITE_DISABLE_CMD, OP_STATUS_READ_CMD, OP_FUNCTION_REG_READ_CMD, 8'h16,
        8'hc8, 8'h61, 8'h81, 8'hab, 8'h9f, 8'h90, 8'haf, 8'h4b, 8'h5a, 8'h82};
    // writable status bits and one-time function bits
    localparam logic [7:0]  SR_WMASK   = 8'hfc;
    localparam logic [7:0]  FR_OTP     = 8'hf2;
    localparam logic [3:0]  SR_BP_ZERO = 4'h0;
    localparam int unsigned SR_BP_LO   = 2;
    // address bits that name a page, sector or block
    localparam logic [23:0] M_PAGE  = 24'hffff00;
    localparam logic [23:0] M_SECT  = 24'hfff000;
    localparam logic [23:0] M_BLK32 = 24'hff8000;
    localparam logic [23:0] M_BLK64 = 24'hff0000;
    // engine states, gray along idle-run-suspend
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RUN  = 2'b01,
        ENG_SUSP = 2'b11
    } fqs_eng_type;
    typedef enum logic [2:0] {
        K_PROG  = 3'h0,
        K_SECT  = 3'h1,
        K_BLK32 = 3'h2,
        K_BLK64 = 3'h3,
        K_CHIP  = 3'h4
    } fqs_kind_type;
    // start request handed to the array engine
    typedef struct packed {
        fqs_kind_type kind;
        logic [23:0]  addr;
    } fqs_req_type;
endpackage

// ===== design/fqs_cmd.sv
// fqs_cmd: command interpreter of a serial flash, SPI and QPI framing
// assumes host pins arrive asynchronously and an array engine outside
// What this block does
// RL1: write disable clears the write enable latch
// RL2: status read works while operations run
// RL3: status write loads protect, lock, quad bits
// RL4: status write needs the latch set first
// RL5: function read shifts out function register
// RL6: function write sets reset-disable and row locks
// RL7: those function bits never return to zero; reset, which models power-up, clears them
// RL8: after quad enter, all phases four bits wide
// RL9: quad exit is one two-clock nibble cycle
// RL10: suspend and resume work in both modes
// RL11: function bit 2 program, 3 erase suspended
// RL12: suspend latency 100us, resume-to-suspend 80us
// RL13: suspend ignored during whole-chip erase
// RL14: erase suspended: no status write, erase, region read
// RL15: program suspended: no status write, program, page read
// RL16: after suspend, busy until settled; host polls
// RL17: entering suspend clears the write enable latch
// RL18: resume restarts operation, clears suspend flag
// RL19: quad cycle is two nibbles, high first
// RL20: host waits resume-to-suspend delay before suspend
// RL21: reads, latch, register and id opcodes taken suspended
// RL22: suspend and resume framed by chip select
// RL23: write enable sets the write enable latch
// RL24: busy bit high while operation runs
// RL25: other opcodes ignored while suspended
`timescale 1ns/100ps
module fqs_cmd
    import fqs_pkg::*;
(
    input  wire logic         clk,           // 10 MHz core clock
    input  wire logic         rst_b,         // async reset
    input  wire logic         sck,           // host serial clock
    input  wire logic         cs_b,          // host chip select
    input  wire logic [3:0]   io_in,         // data pins as received
    output logic [3:0]        io_out,        // data pins driven
    output logic [3:0]        io_oe,         // high while a pin is driven
    input  wire logic         op_done,       // array operation finished
    output logic              array_go,      // start program or erase
    output fqs_req_type       array_req,     // kind and address of start
    output logic              array_suspend, // pause running operation
    output logic              array_resume,  // continue paused operation
    output logic              read_go,       // array read may proceed
    output logic [23:0]       read_addr,     // address of that read
    output logic              read_blocked,  // read hit suspended area
    output logic              qpi_mode,      // four-bit command mode
    output logic [7:0]        stat_reg,      // status byte
    output logic [7:0]        func_reg       // function byte
);
    function automatic logic susp_ok(input logic [7:0] op);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < $size(SUSP_OK); i++) begin
            if (SUSP_OK[i] == op) hit = 1'b1;
        end
        return hit;
    endfunction
    function automatic logic is_sus(input logic [7:0] op);
        return op == OP_SUS_A || op == OP_SUS_B;
    endfunction
    function automatic logic is_rsm(input logic [7:0] op);
        return op == OP_RSM_A || op == OP_RSM_B;
    endfunction
    function automatic logic is_aread(input logic [7:0] op);
        return op inside {OP_RD, OP_FRD, OP_RD_DO, OP_RD_QO, OP_RD_DIO, OP_RD_QIO};
    endfunction
    function automatic logic is_pe(input logic [7:0] op);
        return op inside {OP_PP, OP_PPQ, OP_SE_A, OP_SE_B, OP_BE32, OP_BE64};
    endfunction
    function automatic fqs_kind_type kind_of(input logic [7:0] op);
        fqs_kind_type k;
        if (op == OP_PP || op == OP_PPQ) k = K_PROG;
        else if (op == OP_BE32) k = K_BLK32;
        else if (op == OP_BE64) k = K_BLK64;
        else if (op == OP_CE_A || op == OP_CE_B) k = K_CHIP;
        else k = K_SECT;
        return k;
    endfunction
    // area that a suspended operation keeps unreadable
    function automatic logic in_region(input fqs_kind_type k, input logic [23:0] a,
                                       input logic [23:0] b);
        logic [23:0] m;
        unique case (k)
            K_PROG:  m = M_PAGE;
            K_SECT:  m = M_SECT;
            K_BLK32: m = M_BLK32;
            K_BLK64: m = M_BLK64;
            default: m = 24'h000000;
        endcase
        return ((a ^ b) & m) == 24'h000000;
    endfunction

    logic [5:0]   sync1;
    logic [5:0]   sync2;
    logic         sck_d;
    logic         cs_d;
    logic         rise;
    logic         fall;
    logic         f_start;
    logic         f_end;
    logic [5:0]   cnt;
    logic [5:0]   next_cnt;
    logic [31:0]  sh;
    logic [31:0]  next_sh;
    logic [7:0]   opc;
    logic [7:0]   next_opc;
    logic [7:0]   dat;
    logic [7:0]   next_dat;
    logic [23:0]  addr;
    logic [23:0]  next_addr;
    logic         addr_ev;
    fqs_eng_type  eng;
    fqs_eng_type  next_eng;
    fqs_kind_type kind;
    fqs_kind_type next_kind;
    logic [23:0]  oaddr;
    logic [23:0]  next_oaddr;
    logic         write_enable_latch;
    logic         next_wel;
    logic         op_in_progress_flag;
    logic         next_wip;
    logic         program_suspended_flag;
    logic         next_program_suspended_flag;
    logic         erase_suspended_flag;
    logic         next_erase_suspended_flag;
    logic [7:0]   sr;
    logic [7:0]   next_sr;
    logic [7:0]   otp;
    logic [7:0]   next_otp;
    logic         next_qpi;
    logic [9:0]   settle;
    logic [9:0]   next_settle;
    logic [9:0]   ssc;
    logic [9:0]   next_ssc;
    logic         ok;
    fqs_req_type  next_req;
    logic         next_go;
    logic         next_susp;
    logic         next_rsm;
    logic         next_rgo;
    logic         next_rblk;
    logic [23:0]  next_raddr;
    logic [2:0]   ptr;
    logic [2:0]   next_ptr;
    logic [3:0]   next_io;
    logic [3:0]   next_oe;
    logic         rd_on;
    logic [7:0]   rbyte;

    // two stages on every pin; only edges of the second stage are used
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= 6'h10;
            sync2 <= 6'h10;
            sck_d <= 1'b0;
            cs_d  <= 1'b1;
        end else begin
            sync1 <= {sck, cs_b, io_in};
            sync2 <= sync1;
            sck_d <= sync2[5];
            cs_d  <= sync2[4];
        end
    end
    assign rise    = sync2[5] & ~sck_d & ~sync2[4];
    assign fall    = ~sync2[5] & sck_d & ~sync2[4];
    assign f_start = ~sync2[4] & cs_d;
    assign f_end   = sync2[4] & ~cs_d;   // see RL22

    // receiver: opcode, data byte and address, msb first
    always_comb begin
        logic [2:0] w;
        logic [6:0] sum;
        w         = 3'd1;
        sum       = 7'h00;
        next_cnt  = cnt;
        next_sh   = sh;
        next_opc  = opc;
        next_dat  = dat;
        next_addr = addr;
        addr_ev   = 1'b0;
        if (qpi_mode) w = 3'd4;   // see RL8
        else if (cnt >= 6'd8 && opc == OP_RD_DIO) w = 3'd2;
        else if (cnt >= 6'd8 && opc == OP_RD_QIO) w = 3'd4;
        if (f_start) begin
            next_cnt = 6'h00;
        end else if (rise) begin
            unique case (w)
                3'd4:    next_sh = {sh[27:0], sync2[3:0]};   // see RL19
                3'd2:    next_sh = {sh[29:0], sync2[1:0]};
                default: next_sh = {sh[30:0], sync2[0]};
            endcase
            sum      = {1'b0, cnt} + {4'h0, w};
            next_cnt = sum[6] ? 6'h3f : sum[5:0];
            if (cnt < 6'd8 && next_cnt == 6'd8) next_opc = next_sh[7:0];
            if (cnt < 6'd16 && next_cnt == 6'd16) next_dat = next_sh[7:0];
            if (cnt < 6'd32 && next_cnt == 6'd32) begin
                next_addr = next_sh[23:0];
                addr_ev   = 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt  <= 6'h00;
            sh   <= 32'h00000000;
            opc  <= 8'h00;
            dat  <= 8'h00;
            addr <= 24'h000000;
        end else begin
            cnt  <= next_cnt;
            sh   <= next_sh;
            opc  <= next_opc;
            dat  <= next_dat;
            addr <= next_addr;
        end
    end

    // command execution at the end of each frame, plus the engine
    always_comb begin
        next_eng    = eng;
        next_kind   = kind;
        next_oaddr  = oaddr;
        next_wel    = write_enable_latch;
        next_sr     = sr;
        next_otp    = otp;
        next_qpi    = qpi_mode;
        next_settle = settle;
        next_ssc    = ssc;
        next_req    = array_req;
        next_go     = 1'b0;
        next_susp   = 1'b0;
        next_rsm    = 1'b0;
        next_rgo    = 1'b0;
        next_rblk   = 1'b0;
        next_raddr  = read_addr;
        ok          = settle == 10'h000;   // see RL16
        if (settle != 10'h000) next_settle = settle - 10'd1;
        if (ssc != 10'h000) next_ssc = ssc - 10'd1;   // see RL20
        if (op_done && eng == ENG_RUN) begin
            next_eng = ENG_IDLE;
            next_wel = 1'b0;
        end
        // reads during a run are dropped; suspended ones are checked
        if (addr_ev && ok && is_aread(opc) && eng != ENG_RUN) begin
            next_raddr = next_addr;
            if (eng == ENG_SUSP && in_region(kind, next_addr, oaddr))
                next_rblk = 1'b1;   // see RL14 see RL15
            else
                next_rgo = 1'b1;   // see RL21
        end
        if (f_end && ok) begin
            if (eng == ENG_SUSP && !susp_ok(opc) && !is_rsm(opc)) begin
                next_eng = eng;   // see RL25
            end else if (cnt == 6'd8 && opc == OP_WRITE_DISABLE_CMD) begin
                next_wel = 1'b0;   // see RL1
            end else if (cnt == 6'd8 && opc == OP_WRITE_ENABLE_CMD) begin
                next_wel = 1'b1;   // see RL23
            end else if (cnt >= 6'd16 && opc == OP_STATUS_WRITE_CMD && write_enable_latch && eng == ENG_IDLE) begin
                next_sr  = dat & SR_WMASK;   // see RL3 see RL4 see RL14 see RL15
                next_wel = 1'b0;
            end else if (cnt >= 6'd16 && opc == OP_FUNCTION_REG_WRITE_CMD && write_enable_latch && eng == ENG_IDLE) begin
                next_otp = otp | (dat & FR_OTP);   // see RL6 see RL7
                next_wel = 1'b0;
            end else if (cnt == 6'd8 && opc == OP_QEN && !qpi_mode) begin
                next_qpi = 1'b1;   // see RL8
            end else if (cnt == 6'd8 && opc == OP_QEX && qpi_mode) begin
                next_qpi = 1'b0;   // see RL9
            end else if (cnt == 6'd8 && is_sus(opc) && eng == ENG_RUN && !op_done
                         && kind != K_CHIP && ssc == 10'h000) begin
                next_eng    = ENG_SUSP;   // see RL10 see RL13
                next_settle = SUS_LD;   // see RL12
                next_wel    = 1'b0;   // see RL17
                next_susp   = 1'b1;
            end else if (cnt == 6'd8 && is_rsm(opc) && eng == ENG_SUSP) begin
                next_eng = ENG_RUN;   // see RL18
                next_ssc = SS_LD;   // see RL12
                next_rsm = 1'b1;
            end else if (write_enable_latch && eng == ENG_IDLE && ((cnt >= 6'd32 && is_pe(opc))
                         || (cnt == 6'd8 && kind_of(opc) == K_CHIP && !is_pe(opc)
                         && sr[SR_BP_LO +: 4] == SR_BP_ZERO))) begin
                next_eng   = ENG_RUN;
                next_kind  = kind_of(opc);
                next_oaddr = addr;
                next_req   = '{kind: kind_of(opc), addr: addr};
                next_go    = 1'b1;
            end
        end
        next_wip  = next_eng == ENG_RUN || next_settle != 10'h000;   // see RL24
        next_program_suspended_flag = next_eng == ENG_SUSP && next_kind == K_PROG;   // see RL11
        next_erase_suspended_flag = next_eng == ENG_SUSP && next_kind != K_PROG;
    end
    // reset models power-up: latch, mode and all bits clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            eng           <= ENG_IDLE;
            kind          <= K_PROG;
            oaddr         <= 24'h000000;
            write_enable_latch           <= 1'b0;
            op_in_progress_flag           <= 1'b0;
            program_suspended_flag          <= 1'b0;
            erase_suspended_flag          <= 1'b0;
            sr            <= 8'h00;
            otp           <= 8'h00;
            qpi_mode      <= 1'b0;
            settle        <= 10'h000;
            ssc           <= 10'h000;
            array_req     <= '{kind: K_PROG, addr: 24'h000000};
            array_go      <= 1'b0;
            array_suspend <= 1'b0;
            array_resume  <= 1'b0;
            read_go       <= 1'b0;
            read_blocked  <= 1'b0;
            read_addr     <= 24'h000000;
        end else begin
            eng           <= next_eng;
            kind          <= next_kind;
            oaddr         <= next_oaddr;
            write_enable_latch           <= next_wel;
            op_in_progress_flag           <= next_wip;
            program_suspended_flag          <= next_program_suspended_flag;
            erase_suspended_flag          <= next_erase_suspended_flag;
            sr            <= next_sr;
            otp           <= next_otp;
            qpi_mode      <= next_qpi;
            settle        <= next_settle;
            ssc           <= next_ssc;
            array_req     <= next_req;
            array_go      <= next_go;
            array_suspend <= next_susp;
            array_resume  <= next_rsm;
            read_go       <= next_rgo;
            read_blocked  <= next_rblk;
            read_addr     <= next_raddr;
        end
    end
    assign stat_reg = {sr[7:2], write_enable_latch, op_in_progress_flag};
    assign func_reg = {otp[7:4], erase_suspended_flag, program_suspended_flag, otp[1], 1'b0};

    // read-back of status or function byte on falling sck, repeating
    assign rd_on = cnt >= 6'd8 && (opc == OP_STATUS_READ_CMD || (opc == OP_FUNCTION_REG_READ_CMD && ok));   // see RL2
    assign rbyte = opc == OP_STATUS_READ_CMD ? stat_reg : func_reg;   // see RL5
    always_comb begin
        next_ptr = ptr;
        next_io  = io_out;
        next_oe  = io_oe;
        if (sync2[4] || f_start) begin
            next_ptr = 3'd7;
            next_oe  = 4'h0;
        end else if (fall && rd_on) begin
            if (qpi_mode) begin
                next_io  = ptr[2] ? rbyte[7:4] : rbyte[3:0];
                next_oe  = 4'hf;
                next_ptr = ptr - 3'd4;
            end else begin
                next_io  = {2'b00, rbyte[ptr], 1'b0};
                next_oe  = 4'h2;
                next_ptr = ptr - 3'd1;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr    <= 3'd7;
            io_out <= 4'h0;
            io_oe  <= 4'h0;
        end else begin
            ptr    <= next_ptr;
            io_out <= next_io;
            io_oe  <= next_oe;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence sus_enter_s;
        $rose(eng == ENG_SUSP);
    endsequence
    sequence status_write_cmd_take_s;
        f_end && ok && cnt >= 6'd16 && opc == OP_STATUS_WRITE_CMD && write_enable_latch && eng == ENG_IDLE;
    endsequence
    write_disable_cmd_clear_a: assert property (f_end && ok && cnt == 6'd8 && opc == OP_WRITE_DISABLE_CMD |=> !write_enable_latch) // see RL1
        else $error("write disable left the latch set");
    status_read_cmd_busy_a: assert property (fall && rd_on && opc == OP_STATUS_READ_CMD && eng == ENG_RUN // see RL2
        |=> io_oe != 4'h0) else $error("status not driven during a run");
    status_write_cmd_load_a: assert property (status_write_cmd_take_s |=> sr == ($past(dat) & SR_WMASK)) // see RL3
        else $error("status write loaded wrong bits");
    status_write_cmd_wel_a: assert property (sr != $past(sr) |-> $past(write_enable_latch)) // see RL4
        else $error("status changed without the latch");
    otp_keep_a: assert property (($past(otp) & ~otp) == 8'h00) // see RL7
        else $error("one-time bit returned to zero");
    qpi_exit_a: assert property ($fell(qpi_mode) |-> $past(cnt) == 6'd8 && opc == OP_QEX) // see RL9
        else $error("quad mode left without exit cycle");
    chip_nosus_a: assert property (eng == ENG_RUN && kind == K_CHIP |=> eng != ENG_SUSP) // see RL13
        else $error("chip erase was suspended");
    susp_busy_a: assert property (sus_enter_s |-> settle == SUS_LD ##1 op_in_progress_flag [*8]) // see RL16
        else $error("suspend settle not busy");
    susp_wel_a: assert property (sus_enter_s |-> !write_enable_latch && array_suspend) // see RL17
        else $error("suspend left the latch set");
    resume_clr_a: assert property ($fell(eng == ENG_SUSP) && eng == ENG_RUN // see RL18
        |-> !program_suspended_flag && !erase_suspended_flag && array_resume) else $error("resume left flag set");
    blocked_read_a: assert property (read_blocked |-> !read_go && eng == ENG_SUSP) // see RL14
        else $error("blocked read not in suspend");
    susp_ignore_a: assert property (eng == ENG_SUSP && f_end && !susp_ok(opc) // see RL25
        && !is_rsm(opc) |=> $stable(sr) && $stable(otp) && eng == ENG_SUSP)
        else $error("foreign opcode acted during suspend");
endmodule

// ===== testbench/fqs_host.sv
// fqs_host: behavioural host controller on the flash pins
// assumes a 100 ns bench clock; sck runs at 800 ns inside frames only
`timescale 1ns/100ps
module fqs_host (
    input  wire logic       clk,    // bench clock, pacing only
    output logic            sck,    // serial clock, low between frames
    output logic            cs_b,   // chip select
    output logic [3:0]      io_in,  // data pins towards the device
    input  wire logic [3:0] io_out, // data pins from the device
    input  wire logic [3:0] io_oe   // output enables from the device
);
    logic [3:0] io_seen;
    // an undriven pin reads back inverted, never as a stale valid value
    assign io_seen = io_out ^ ~io_oe;
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        io_in = 4'h0;
    end
    // n bits msb first, w bits a clock; rd keeps the last byte seen
    task automatic frame(input logic [39:0] d, input int n, input int w,
                         output logic [7:0] rd);
        logic [15:0] cap;
        cap = '0;
        @(posedge clk);
        cs_b <= 1'b0;
        for (int i = 0; i < n; i += w) begin
            io_in <= (w == 4) ? d[n-1-i -: 4] : {3'h0, d[n-1-i]};
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            // sampled late in the high phase: output lags by the sync flops
            repeat (3) @(posedge clk);
            cap = (w == 4) ? {cap[11:0], io_seen} : {cap[14:0], io_seen[1]};
            @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_b <= 1'b1;
        io_in <= ~io_in; // a released line does not keep its last value
        rd = cap[7:0];
        repeat (4) @(posedge clk);
    endtask
endmodule

// ===== testbench/tb_top.sv
// tb_top: bench of the command interpreter, host model on the pins
// assumes fqs_cmd alone; the array engine is played by op_done pulses
`timescale 1ns/100ps
module tb_top;
    import fqs_pkg::*;
    typedef struct {
        logic [39:0] cmd;
        int          nb;
        logic [7:0]  smask;
        logic [7:0]  sexp;
        logic [7:0]  fmask;
        logic [7:0]  fexp;
    } fqs_row_type;
    logic       clk, rst_b, op_done, sck, cs_b, qpi_mode;
    logic       array_go, array_suspend, array_resume, read_go, read_blocked;
    logic [3:0] io_in, io_out, io_oe;
    logic [7:0] stat_reg, func_reg, rd, sus_cnt, rsm_cnt, blk_cnt, rgo_cnt;
    int         error_cnt, check_count;
    fqs_row_type rows [11] = '{
        '{40'h06, 8, 8'hff, 8'h02, 8'h00, 8'h00},
        '{40'h04, 8, 8'hff, 8'h00, 8'h00, 8'h00},
        '{40'h01fc, 16, 8'hfc, 8'h00, 8'h00, 8'h00},
        '{40'h06, 8, 8'h02, 8'h02, 8'h00, 8'h00},
        '{40'h01fc, 16, 8'hfc, 8'hfc, 8'h00, 8'h00},
        '{40'h06, 8, 8'h02, 8'h02, 8'h00, 8'h00},
        '{40'h42f2, 16, 8'h00, 8'h00, 8'hf2, 8'hf2},
        '{40'h06, 8, 8'h02, 8'h02, 8'h00, 8'h00},
        '{40'h4200, 16, 8'h00, 8'h00, 8'hf2, 8'hf2},
        '{40'h06, 8, 8'h02, 8'h02, 8'h00, 8'h00},
        '{40'h0100, 16, 8'hfc, 8'h00, 8'hf2, 8'hf2}};
    fqs_cmd dut (.clk, .rst_b, .sck, .cs_b, .io_in, .io_out, .io_oe, .op_done,
        .array_go, .array_req(), .array_suspend, .array_resume, .read_go,
        .read_addr(), .read_blocked, .qpi_mode, .stat_reg, .func_reg);
    fqs_host host (.clk, .sck, .cs_b, .io_in, .io_out, .io_oe);
    always #50 clk = ~clk;
    // pulse counters, since pulses stand for one cycle only
    always @(posedge clk) begin
        sus_cnt <= sus_cnt + {7'h0, array_suspend};
        rsm_cnt <= rsm_cnt + {7'h0, array_resume};
        blk_cnt <= blk_cnt + {7'h0, read_blocked};
        rgo_cnt <= rgo_cnt + {7'h0, read_go};
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // frame, then the few cycles that cs_b rise takes to act
    task automatic send(input logic [39:0] d, input int n, input int w);
        host.frame(d, n, w, rd);
        repeat (4) @(posedge clk);
    endtask
    task automatic done_pulse();
        @(posedge clk);
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        op_done = 1'b0;
        {sus_cnt, rsm_cnt, blk_cnt, rgo_cnt} = '0;
        error_cnt = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        // latch, status and function writes from the table
        foreach (rows[i]) begin
            send(rows[i].cmd, rows[i].nb, 1);
            chk("stat_reg", rows[i].sexp, stat_reg & rows[i].smask);
            chk("func_reg", rows[i].fexp, func_reg & rows[i].fmask);
        end
        send(40'h4800, 16, 1);
        chk("func_read", 8'hf2, rd);
        // sector erase, suspend, busy while settling
        send(40'h06, 8, 1);
        send(40'h20012345, 32, 1);
        chk("wip_run", 8'h01, stat_reg & 8'h01);
        send(40'h0500, 16, 1);
        chk("stat_run", 8'h03, rd);
        send(40'h75, 8, 1);
        chk("erase_susp", 8'h08, func_reg & 8'h0c);
        chk("wel_susp", 8'h00, stat_reg & 8'h02);
        send(40'h0500, 16, 1);
        chk("stat_read", 8'h01, rd);
        repeat (1000) @(posedge clk);
        send(40'h06, 8, 1);
        send(40'h01fc, 16, 1);
        chk("stat_locked", 8'h00, stat_reg & 8'hfc);
        send(40'h03012800, 32, 1);
        send(40'h03013000, 32, 1);
        chk("read_block", 8'h01, blk_cnt);
        chk("read_go", 8'h01, rgo_cnt);
        send(40'h7a, 8, 1);
        chk("resumed", 8'h00, func_reg & 8'h08);
        send(40'h75, 8, 1);
        chk("sus_too_soon", 8'h01, sus_cnt);
        done_pulse();
        chk("wip_done", 8'h00, stat_reg & 8'h01);
        // chip erase cannot be suspended
        repeat (800) @(posedge clk);
        send(40'h06, 8, 1);
        send(40'hc7, 8, 1);
        send(40'h75, 8, 1);
        chk("chip_no_sus", 8'h01, sus_cnt);
        done_pulse();
        // four-bit mode: program, suspend and resume
        send(40'h35, 8, 1);
        chk("qpi_on", 8'h01, {7'h0, qpi_mode});
        send(40'h06, 8, 4);
        send(40'h02012345aa, 40, 4);
        send(40'hb0, 8, 4);
        chk("prog_susp", 8'h04, func_reg & 8'h0c);
        send(40'h0500, 16, 4);
        chk("qpi_stat", 8'h01, rd);
        repeat (1000) @(posedge clk);
        send(40'h03012300, 32, 4);
        chk("page_block", 8'h02, blk_cnt);
        send(40'h30, 8, 4);
        chk("qpi_resume", 8'h02, rsm_cnt);
        done_pulse();
        send(40'hf5, 8, 4);
        chk("qpi_off", 8'h00, {7'h0, qpi_mode});
        // power cycle in quad mode: back to single-bit framing
        send(40'h35, 8, 1);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk("qpi_reset", 8'h00, {7'h0, qpi_mode});
        send(40'h0500, 16, 1);
        chk("stat_reset", 8'h00, rd);
        results();
    end
endmodule
